// [inc/station_cfg_pkg.sv]
// Constants, types and register map for the station state and configuration decoder.
package station_cfg_pkg;

  localparam int N_STN  = 8;
  localparam int STN_W  = 3;
  localparam int ADDR_W = 8;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_BYTE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STN_STATE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STN_LEN    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CFG_LAST   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SELF_STATE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATES_LO  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATES_HI  = 8'h1C;

  // Control register fields.
  localparam int CTRL_GATEWAY_BIT = 0;
  localparam int CTRL_SLAVE_BIT   = 1;
  localparam int CTRL_SEL_LSB     = 8;
  localparam int CTRL_CLEAR_BIT   = 16;

  // Identifier byte fields.
  localparam logic [3:0] ID_NO_DATA   = 4'h0;
  localparam logic [3:0] ID_SPEC_IN   = 4'h4;
  localparam logic [3:0] ID_SPEC_OUT  = 4'h8;
  localparam logic [3:0] ID_SPEC_BOTH = 4'hC;
  localparam int ID_CONS_BIT = 3;
  localparam int ID_WORD_BIT = 2;
  localparam int ID_OUT_BIT  = 1;
  localparam int ID_IN_BIT   = 0;
  localparam int DESC_CONS_BIT = 7;
  localparam int DESC_WORD_BIT = 6;

  // Station state codes.
  localparam logic [7:0] ST_OK           = 8'h00;
  localparam logic [7:0] ST_DEACTIVATED  = 8'h01;
  localparam logic [7:0] ST_NO_REPLY     = 8'h02;
  localparam logic [7:0] ST_MASTER_LOCK  = 8'h03;
  localparam logic [7:0] ST_INVALID_RESP = 8'h04;
  localparam logic [7:0] ST_PRM_FAULT    = 8'h05;
  localparam logic [7:0] ST_NOT_SUPP     = 8'h06;
  localparam logic [7:0] ST_CFG_FAULT    = 8'h07;
  localparam logic [7:0] ST_NOT_READY    = 8'h08;
  localparam logic [7:0] ST_STAT_DIAG    = 8'h09;
  localparam logic [7:0] ST_DIAG_OVF     = 8'h0A;
  localparam logic [7:0] ST_PHYS_FAULT   = 8'h0B;
  localparam logic [7:0] ST_SEVERE_BUS   = 8'h0D;
  localparam logic [7:0] ST_TELEGRAM     = 8'h0E;
  localparam logic [7:0] ST_NO_RES       = 8'h0F;
  localparam logic [7:0] ST_SERVICE_OFF  = 8'h10;
  localparam logic [7:0] ST_UNEXPECTED   = 8'h11;
  localparam logic [7:0] ST_READY_WAIT   = 8'h12;
  localparam logic [7:0] ST_ACYC_PEND    = 8'h13;
  localparam logic [7:0] ST_GW_WC        = 8'h1F;
  localparam logic [7:0] ST_SLV_DATA     = 8'h80;
  localparam logic [7:0] ST_SLV_CFG      = 8'h81;
  localparam logic [7:0] ST_SLV_PRM      = 8'h82;

  localparam logic [1:0] WC_FAULT = 2'h1;

  // Condition flags reported per station by the bus engine.
  typedef struct packed {
    logic deactivated;
    logic no_reply;
    logic master_lock;
    logic invalid_resp;
    logic prm_fault;
    logic not_supported;
    logic cfg_fault;
    logic not_ready;
    logic stat_diag;
    logic diag_overflow;
    logic phys_fault;
    logic severe_bus;
    logic telegram_fault;
    logic no_resources;
    logic service_off;
    logic unexpected;
    logic ready_wait;
    logic acyc_pending;
  } station_cond_t;

  // Phase of this device when it runs as a bus slave itself.
  typedef enum logic [1:0] {
    SLV_WAIT_PRM  = 2'h0,
    SLV_WAIT_CFG  = 2'h1,
    SLV_WAIT_DATA = 2'h2,
    SLV_RUN       = 2'h3
  } slave_phase_t;

  // Summary of the last decoded data-carrying module.
  typedef struct packed {
    logic       has_in;
    logic       has_out;
    logic       word_unit;
    logic       consistent;
    logic [7:0] units;
  } module_desc_t;

endpackage : station_cfg_pkg

// [logic/station_cfg_decoder.sv]
// Station state encoder and configuration identifier decoder behind an APB slave.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module station_cfg_decoder
  import station_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Bus engine status, same clock
  input  wire station_cond_t [N_STN-1:0]   station_cond,
  input  wire logic [1:0]                  working_counter_state,
  input  wire slave_phase_t                own_slave_phase,
  // Live state codes
  output logic      [N_STN*8-1:0]          station_state_code
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------

  // Fixed priority: faults that stop all traffic mask the finer answers.
  function automatic logic [7:0] encode_state(input station_cond_t c, input logic gw_fault);
    logic [7:0] code;
    code = ST_OK;
    if (gw_fault) code = ST_GW_WC;
    else if (c.deactivated) code = ST_DEACTIVATED;
    else if (c.no_reply) code = ST_NO_REPLY;
    else if (c.phys_fault) code = ST_PHYS_FAULT;
    else if (c.severe_bus) code = ST_SEVERE_BUS;
    else if (c.telegram_fault) code = ST_TELEGRAM;
    else if (c.unexpected) code = ST_UNEXPECTED;
    else if (c.master_lock) code = ST_MASTER_LOCK;
    else if (c.invalid_resp) code = ST_INVALID_RESP;
    else if (c.no_resources) code = ST_NO_RES;
    else if (c.service_off) code = ST_SERVICE_OFF;
    else if (c.prm_fault) code = ST_PRM_FAULT;
    else if (c.not_supported) code = ST_NOT_SUPP;
    else if (c.cfg_fault) code = ST_CFG_FAULT;
    else if (c.diag_overflow) code = ST_DIAG_OVF;
    else if (c.stat_diag) code = ST_STAT_DIAG;
    else if (c.not_ready) code = ST_NOT_READY;
    else if (c.ready_wait) code = ST_READY_WAIT;
    else if (c.acyc_pending) code = ST_ACYC_PEND;
    return code;
  endfunction : encode_state

  // Length field holds units minus one; word units are two bytes each.
  function automatic logic [7:0] unit_bytes(input logic [5:0] len_m1, input logic word);
    logic [7:0] units;
    units = {2'b00, len_m1} + 8'h01;
    return word ? {units[6:0], 1'b0} : units;
  endfunction : unit_bytes

  function automatic logic [7:0] unit_count(input logic [5:0] len_m1);
    return {2'b00, len_m1} + 8'h01;
  endfunction : unit_count

  // ---------------------------------------------------------------------------
  // Station state codes
  // ---------------------------------------------------------------------------

  logic [7:0] state_r [N_STN];
  logic       gw_fault;
  logic       gateway_en_r;
  logic       slave_en_r;
  logic [7:0] self_state_r;

  assign gw_fault = gateway_en_r && (working_counter_state == WC_FAULT);

  genvar gi;
  generate
    for (gi = 0; gi < N_STN; gi++) begin : g_stn
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state_r[gi] <= ST_DEACTIVATED;
        end else begin
          state_r[gi] <= encode_state(station_cond[gi], gw_fault);
        end
      end
      assign station_state_code[gi*8 +: 8] = state_r[gi];
    end
  endgenerate

  // Reports this device's own progress while it serves as a bus slave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_state_r <= ST_OK;
    end else if (!slave_en_r) begin
      self_state_r <= ST_OK;
    end else begin
      unique case (own_slave_phase)
        SLV_WAIT_PRM:  self_state_r <= ST_SLV_PRM;
        SLV_WAIT_CFG:  self_state_r <= ST_SLV_CFG;
        SLV_WAIT_DATA: self_state_r <= ST_SLV_DATA;
        SLV_RUN:       self_state_r <= ST_OK;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------

  logic             wr_en;
  logic             setup;
  logic             addr_ok;
  logic [STN_W-1:0] sel_r;
  logic             clear_pulse;
  logic             byte_pulse;

  assign setup       = psel && !penable;
  assign wr_en       = psel && penable && pwrite && addr_ok;
  assign clear_pulse = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_CLEAR_BIT];
  assign byte_pulse  = wr_en && (paddr == OFS_CFG_BYTE);

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_CFG_BYTE, OFS_STN_STATE, OFS_STN_LEN,
      OFS_CFG_LAST, OFS_SELF_STATE, OFS_STATES_LO, OFS_STATES_HI: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gateway_en_r <= 1'b0;
      slave_en_r   <= 1'b0;
      sel_r        <= '0;
    end else if (wr_en && (paddr == OFS_CTRL)) begin
      gateway_en_r <= pwdata[CTRL_GATEWAY_BIT];
      slave_en_r   <= pwdata[CTRL_SLAVE_BIT];
      sel_r        <= pwdata[CTRL_SEL_LSB +: STN_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Identifier byte parser
  // ---------------------------------------------------------------------------

  typedef enum logic [1:0] {
    P_IDENT,
    P_DESC_OUT,
    P_DESC_IN,
    P_SKIP
  } parse_t;

  parse_t       pstate_r;
  logic [3:0]   skip_r;
  logic         both_r;
  logic         err_r;
  logic [15:0]  in_len_r  [N_STN];
  logic [15:0]  out_len_r [N_STN];
  module_desc_t last_r;
  logic [7:0]   cbyte;
  logic [7:0]   add_in;
  logic [7:0]   add_out;
  logic         add_valid;
  module_desc_t desc_nxt;

  assign cbyte = pwdata[7:0];

  // Works out what one identifier or descriptor byte contributes.
  always_comb begin
    add_in    = 8'h00;
    add_out   = 8'h00;
    add_valid = 1'b0;
    desc_nxt  = '0;
    if (pstate_r == P_IDENT) begin
      if (cbyte[7:4] != ID_NO_DATA && cbyte[7:4] != ID_SPEC_IN &&
          cbyte[7:4] != ID_SPEC_OUT && cbyte[7:4] != ID_SPEC_BOTH) begin
        add_valid           = 1'b1;
        desc_nxt.has_in     = cbyte[4 + ID_IN_BIT];
        desc_nxt.has_out    = cbyte[4 + ID_OUT_BIT];
        desc_nxt.word_unit  = cbyte[4 + ID_WORD_BIT];
        desc_nxt.consistent = cbyte[4 + ID_CONS_BIT];
        desc_nxt.units      = unit_count({2'b00, cbyte[3:0]});
        if (desc_nxt.has_in) begin
          add_in = unit_bytes({2'b00, cbyte[3:0]}, desc_nxt.word_unit);
        end
        if (desc_nxt.has_out) begin
          add_out = unit_bytes({2'b00, cbyte[3:0]}, desc_nxt.word_unit);
        end
      end
    end else if (pstate_r == P_DESC_OUT || pstate_r == P_DESC_IN) begin
      add_valid           = 1'b1;
      desc_nxt.has_in     = (pstate_r == P_DESC_IN);
      desc_nxt.has_out    = (pstate_r == P_DESC_OUT);
      desc_nxt.word_unit  = cbyte[DESC_WORD_BIT];
      desc_nxt.consistent = cbyte[DESC_CONS_BIT];
      desc_nxt.units      = unit_count(cbyte[5:0]);
      if (desc_nxt.has_in) begin
        add_in = unit_bytes(cbyte[5:0], desc_nxt.word_unit);
      end else begin
        add_out = unit_bytes(cbyte[5:0], desc_nxt.word_unit);
      end
    end
  end

  // Sequence through identifier, descriptors and trailing vendor bytes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_r <= P_IDENT;
      skip_r   <= '0;
      both_r   <= 1'b0;
    end else if (clear_pulse) begin
      pstate_r <= P_IDENT;
      skip_r   <= '0;
      both_r   <= 1'b0;
    end else if (byte_pulse) begin
      unique case (pstate_r)
        P_IDENT: begin
          skip_r <= cbyte[3:0];
          both_r <= (cbyte[7:4] == ID_SPEC_BOTH);
          if (cbyte[7:4] == ID_NO_DATA) begin
            pstate_r <= (cbyte[3:0] != 4'h0) ? P_SKIP : P_IDENT;
          end else if (cbyte[7:4] == ID_SPEC_IN) begin
            pstate_r <= P_DESC_IN;
          end else if (cbyte[7:4] == ID_SPEC_OUT || cbyte[7:4] == ID_SPEC_BOTH) begin
            pstate_r <= P_DESC_OUT;
          end else begin
            pstate_r <= P_IDENT;
          end
        end
        P_DESC_OUT: begin
          if (both_r) begin
            pstate_r <= P_DESC_IN;
          end else begin
            pstate_r <= (skip_r != 4'h0) ? P_SKIP : P_IDENT;
          end
        end
        P_DESC_IN: begin
          pstate_r <= (skip_r != 4'h0) ? P_SKIP : P_IDENT;
        end
        P_SKIP: begin
          skip_r <= skip_r - 4'h1;
          if (skip_r == 4'h1) begin
            pstate_r <= P_IDENT;
          end
        end
      endcase
    end
  end

  // Flags a total that would wrap; the total then saturates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (clear_pulse) begin
      err_r <= 1'b0;
    end else if (byte_pulse && add_valid &&
                 ((in_len_r[sel_r] > 16'hFFFF - {8'h00, add_in}) ||
                  (out_len_r[sel_r] > 16'hFFFF - {8'h00, add_out}))) begin
      err_r <= 1'b1;
    end
  end

  generate
    for (gi = 0; gi < N_STN; gi++) begin : g_len
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_len_r[gi]  <= '0;
          out_len_r[gi] <= '0;
        end else if (clear_pulse && sel_r == STN_W'(gi)) begin
          in_len_r[gi]  <= '0;
          out_len_r[gi] <= '0;
        end else if (byte_pulse && add_valid && sel_r == STN_W'(gi)) begin
          in_len_r[gi]  <= (in_len_r[gi] > 16'hFFFF - {8'h00, add_in}) ?
                           16'hFFFF : in_len_r[gi] + {8'h00, add_in};
          out_len_r[gi] <= (out_len_r[gi] > 16'hFFFF - {8'h00, add_out}) ?
                           16'hFFFF : out_len_r[gi] + {8'h00, add_out};
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= '0;
    end else if (clear_pulse) begin
      last_r <= '0;
    end else if (byte_pulse && add_valid) begin
      last_r <= desc_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------

  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: begin
        rdata_nxt[CTRL_GATEWAY_BIT]          = gateway_en_r;
        rdata_nxt[CTRL_SLAVE_BIT]            = slave_en_r;
        rdata_nxt[CTRL_SEL_LSB +: STN_W]     = sel_r;
      end
      OFS_CFG_BYTE:   rdata_nxt = {24'h00_0000, err_r, 1'b0, skip_r, pstate_r};
      OFS_STN_STATE:  rdata_nxt = {24'h00_0000, state_r[sel_r]};
      OFS_STN_LEN:    rdata_nxt = {out_len_r[sel_r], in_len_r[sel_r]};
      OFS_CFG_LAST:   rdata_nxt = {20'h0_0000, last_r};
      OFS_SELF_STATE: rdata_nxt = {24'h00_0000, self_state_r};
      OFS_STATES_LO:  rdata_nxt = {state_r[3], state_r[2], state_r[1], state_r[0]};
      OFS_STATES_HI:  rdata_nxt = {state_r[7], state_r[6], state_r[5], state_r[4]};
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Sampled in the setup cycle so the access phase sees a stable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule : station_cfg_decoder

// [verif/station_bus_model.sv]
// Behavioural model of the condition flags reported for the remote stations.
`timescale 1ns/1ps
module station_bus_model
  import station_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Test control
  input  wire logic                    load,
  input  wire logic [STN_W-1:0]        load_stn,
  input  wire station_cond_t           load_cond,
  // Flags seen by the decoder
  output station_cond_t [N_STN-1:0]    station_cond
);
  // Flags change only at clock edges, as the bus engine publishes them once per poll.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_cond <= '0;
    end else if (load) begin
      station_cond[load_stn] <= load_cond;
    end
  end
endmodule : station_bus_model

// [verif/station_cfg_decoder_assertions.sv]
// Concurrent checks on the ports of the station decoder.
`timescale 1ns/1ps
module station_cfg_decoder_assertions
  import station_cfg_pkg::*;
(
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // APB slave
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ADDR_W-1:0]         paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Status and codes
  input wire station_cond_t [N_STN-1:0] station_cond,
  input wire logic [1:0]                working_counter_state,
  input wire slave_phase_t              own_slave_phase,
  input wire logic [N_STN*8-1:0]        station_state_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] code0;
  logic [7:0] code7;
  logic       wc_ok;
  assign code0 = station_state_code[7:0];
  assign code7 = station_state_code[63:56];
  assign wc_ok = working_counter_state != WC_FAULT;

  ready_always_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  err_unmapped_a: assert property (psel && penable && paddr > OFS_STATES_HI |-> pslverr)
    else $error("unmapped access not refused");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved outside read setup");
  ok_code_a: assert property (presetn && station_cond[0] == '0 && wc_ok |=> code0 == ST_OK)
    else $error("clean station not code 0");
  deact_code_a: assert property (station_cond[0].deactivated && wc_ok |=> code0 == 8'h01)
    else $error("deactivated station not code 1");
  noreply_code_a: assert property (station_cond[0].no_reply && !station_cond[0].deactivated
    && wc_ok |=> code0 == 8'h02) else $error("silent station not code 2");
  lock_code_a: assert property (station_cond[7] == 18'h08000 && wc_ok |=> code7 == 8'h03)
    else $error("locked station not code 3");
  legal_code_a: assert property (code0 inside {[8'h00:8'h0B], [8'h0D:8'h13], 8'h1F})
    else $error("undefined state code");
  no_gw_code_a: assert property (wc_ok |=> code0 != ST_GW_WC)
    else $error("gateway code without fault");
  code_steady_a: assert property ((presetn && $stable(station_cond[0])
    && $stable(working_counter_state) && !(psel && penable && pwrite)) [*2]
    |=> $stable(code0)) else $error("code drifted");
endmodule : station_cfg_decoder_assertions

bind station_cfg_decoder station_cfg_decoder_assertions station_cfg_decoder_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .station_cond(station_cond), .working_counter_state(working_counter_state),
  .own_slave_phase(own_slave_phase), .station_state_code(station_state_code));

// [verif/station_cfg_decoder_tb.sv]
// Self-checking bench for the station state encoder and identifier decoder.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module station_cfg_decoder_tb;
  import station_cfg_pkg::*;
  // Flag bits in falling priority, and the code each flag bit stands for.
  localparam int PRI[18] = '{17, 16, 7, 6, 5, 2, 15, 14, 4, 3, 13, 12, 11, 8, 9, 10, 1, 0};
  localparam logic [7:0] CODE[18] = '{8'h13, 8'h12, 8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h0B,
    8'h0A, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
  localparam logic [7:0] SPEC[13] = '{8'hC1, 8'h47, 8'h81, 8'hAA, 8'h40, 8'hFF, 8'h80, 8'h3F,
    8'h02, 8'h13, 8'h13, 8'h10, 8'h00};
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, load, gw, e;
  logic [ADDR_W-1:0]         paddr;
  logic [31:0]               pwdata, prdata, q;
  logic [1:0]                wc;
  logic [3:0]                hi, lo;
  logic [STN_W-1:0]          load_stn;
  station_cond_t             load_cond;
  station_cond_t [N_STN-1:0] cond;
  station_cond_t             cur [N_STN];
  slave_phase_t              phase;
  logic [N_STN*8-1:0]        codes, exp_v;
  int                        err_total, samples_checked, ein, eout, u, nb;

  station_bus_model station_bus_model_i (.pclk(pclk), .presetn(presetn), .load(load),
    .load_stn(load_stn), .load_cond(load_cond), .station_cond(cond));
  station_cfg_decoder station_cfg_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .station_cond(cond), .working_counter_state(wc),
    .own_slave_phase(phase), .station_state_code(codes));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_code(logic [17:0] c, logic hit);
    if (hit) return 8'h1F;
    foreach (PRI[i]) if (c[PRI[i]]) return CODE[PRI[i]];
    return 8'h00;
  endfunction : exp_code

  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Entered just after a rising edge; returns one idle edge later so transfers never collide.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic settle_and_check;
    repeat (2) @(posedge pclk);
    foreach (cur[s]) exp_v[s*8+:8] = exp_code(cur[s], gw && wc == WC_FAULT);
    `CHK("codes", exp_v, codes)
  endtask : settle_and_check

  task automatic put(input logic [STN_W-1:0] s, input station_cond_t c);
    load      <= 1'b1;
    load_stn  <= s;
    load_cond <= c;
    cur[s]    = c;
    @(posedge pclk);
    load      <= 1'b0;
    settle_and_check();
  endtask : put

  task automatic start_stn(input logic [STN_W-1:0] s);
    apb(1'b1, OFS_CTRL, 32'(s) << 8);
    apb(1'b1, OFS_CTRL, (32'(s) << 8) | 32'h0001_0000);
    apb(1'b0, OFS_STN_LEN, '0);
    `CHK("cleared totals", 32'h0, q)
    ein  = 0;
    eout = 0;
  endtask : start_stn

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // The full run needs well under 4000 cycles.
  initial begin
    repeat (4000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, load, gw} = '0;
    paddr = '0;
    pwdata = '0;
    wc = 2'h0;
    load_stn = '0;
    load_cond = '0;
    phase = SLV_WAIT_PRM;
    presetn = 1'b0;
    err_total = 0;
    samples_checked = 0;
    foreach (cur[s]) cur[s] = '0;
    void'($urandom(44));
    repeat (3) @(posedge pclk);
    `CHK("reset codes", {N_STN{8'h01}}, codes)
    presetn <= 1'b1;
    for (int k = 0; k < 18; k++) put(3'(k % 8), station_cond_t'(18'h1 << k));
    for (int i = 0; i < 40; i++) begin
      wc <= 2'($urandom % 4);
      put(3'($urandom % 8), station_cond_t'(18'($urandom & $urandom & $urandom)));
      apb(1'b0, (i % 2) ? OFS_STATES_HI : OFS_STATES_LO, '0);
      `CHK("state regs", exp_v[(i%2)*32+:32], q)
    end
    wc <= 2'h0;
    put(3'h0, station_cond_t'(18'h3_0000));
    put(3'h0, '0);
    start_stn(3'($urandom % 8));
    for (int i = 0; i < 30; i++) begin
      do hi = 4'($urandom); while (hi[1:0] == 2'h0);
      lo = 4'($urandom);
      u = lo + 1;
      nb = hi[2] ? 2 * u : u;
      if (hi[0]) ein += nb;
      if (hi[1]) eout += nb;
      apb(1'b1, OFS_CFG_BYTE, {24'h0, hi, lo});
      apb(1'b0, OFS_CFG_LAST, '0);
      `CHK("last module", {20'h0, hi[0], hi[1], hi[2], hi[3], 8'(u)}, q)
      apb(1'b0, OFS_STN_LEN, '0);
      `CHK("totals", {16'(eout), 16'(ein)}, q)
    end
    foreach (SPEC[i]) apb(1'b1, OFS_CFG_BYTE, {24'h0, SPEC[i]});
    ein  += 131;
    eout += 80;
    apb(1'b0, OFS_STN_LEN, '0);
    `CHK("special totals", {16'(eout), 16'(ein)}, q)
    apb(1'b0, OFS_CFG_BYTE, '0);
    `CHK("parser idle", 2'h0, q[1:0])
    apb(1'b1, OFS_STN_LEN, 32'hFFFF_FFFF);
    apb(1'b0, OFS_STN_LEN, '0);
    `CHK("read only", {16'(eout), 16'(ein)}, q)
    `CHK("mapped err", 1'b0, e)
    start_stn(3'h5);
    apb(1'b0, OFS_STN_STATE, '0);
    `CHK("station state", {24'h0, exp_v[5*8+:8]}, q)
    apb(1'b0, OFS_SELF_STATE, '0);
    `CHK("own state off", 32'h0, q)
    apb(1'b0, 8'h20, '0);
    `CHK("unmapped data", 32'h0, q)
    `CHK("unmapped err", 1'b1, e)
    apb(1'b1, OFS_CTRL, 32'h2);
    for (int p = 0; p < 4; p++) begin
      phase <= slave_phase_t'(p);
      @(posedge pclk);
      apb(1'b0, OFS_SELF_STATE, '0);
      `CHK("own state", (p == 3) ? 32'h0 : 32'(130 - p), q)
    end
    gw = 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1);
    wc <= WC_FAULT;
    settle_and_check();
    wc <= 2'h2;
    settle_and_check();
    tally_and_finish();
  end
endmodule : station_cfg_decoder_tb
